// ---- hbrp_bus_asserts.sv ----
// Concurrent checks on the shared request bus between the hub and the host ends.
`timescale 1ns/1ps
module hbrp_bus_asserts import hbrp_pkg::*; (
  input wire logic i_clk_sys, // Bus clock.
  input wire logic i_resetn, // Sync reset, active low.
  input wire logic request_strobe_n, // Resolved strobe line.
  input wire logic block_next_req_n, // Resolved block line.
  input wire logic bus_fault_pin_n, // Resolved fault line.
  input wire logic [HBRP_ADDR_W-1:0] host_addr_n, // Resolved address lines.
  input wire logic [HBRP_TYPE_W-1:0] req_type_n, // Resolved type lines.
  input wire logic [HBRP_PAR_W-1:0] request_parity_n, // Resolved parity lines.
  input wire logic dev_strobe_o, // Hub strobe level.
  input wire logic dev_strobe_oe, // Hub strobe enable.
  input wire logic dev_addr_oe, // Hub address enable.
  input wire logic host_addr_oe, // Host address enable.
  input wire logic dev_par_oe, // Hub parity enable.
  input wire logic host_par_oe, // Host parity enable.
  input wire logic dev_bnr_o, // Hub block level.
  input wire logic dev_bnr_oe, // Hub block enable.
  input wire logic dev_fault_oe // Hub fault enable.
);
  // All checks share the bus clock and its reset.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  // Strobe lasts one clock and requests are spaced.
  property p_strobe_pulse;
    $fell(request_strobe_n) |=> request_strobe_n [*3];
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe not a single clock");
  // Exactly one agent drives the request lines with the strobe.
  property p_strobe_addr;
    !request_strobe_n |-> (dev_addr_oe ^ host_addr_oe);
  endproperty
  a_strobe_addr: assert property (p_strobe_addr) else $error("strobe without one owner");
  // Hub parity follows its strobe by one clock for two clocks.
  property p_par_drive;
    (dev_strobe_oe && !dev_strobe_o) |=> dev_par_oe [*2] ##1 !dev_par_oe;
  endproperty
  a_par_drive: assert property (p_par_drive) else $error("parity drive window wrong");
  // First sub-phase parity, one clock late, has an even count of lows.
  property p_par_a;
    !request_strobe_n |=> (^(~{$past(host_addr_n[32:21]), request_parity_n[0]}) == 1'b0)
      && (^(~{$past(host_addr_n[20:0]), $past(req_type_n), request_parity_n[1]}) == 1'b0);
  endproperty
  a_par_a: assert property (p_par_a) else $error("first sub-phase parity wrong");
  // Second sub-phase parity uses the swapped groups.
  property p_par_b;
    !request_strobe_n ##1 1'b1 |=> (^(~{$past(host_addr_n[32:21]), request_parity_n[1]}) == 1'b0)
      && (^(~{$past(host_addr_n[20:0]), $past(req_type_n), request_parity_n[0]}) == 1'b0);
  endproperty
  a_par_b: assert property (p_par_b) else $error("second sub-phase parity wrong");
  // The fault pin is never driven and stays pulled up.
  property p_fault;
    !dev_fault_oe && bus_fault_pin_n;
  endproperty
  a_fault: assert property (p_fault) else $error("fault pin driven");
  // No request starts from an accept made while blocked.
  property p_block;
    $fell(request_strobe_n) |-> $past(block_next_req_n);
  endproperty
  a_block: assert property (p_block) else $error("request issued while blocked");
  // The hub block line is driven inactive before release.
  property p_bnr_inactive;
    $fell(dev_bnr_oe) |-> $past(dev_bnr_o);
  endproperty
  a_bnr_inactive: assert property (p_bnr_inactive) else $error("block released while active");
  // Released hub parity lines keep their last level.
  property p_keep;
    $fell(dev_par_oe) && !host_par_oe |-> $stable(request_parity_n);
  endproperty
  a_keep: assert property (p_keep) else $error("parity lines not kept");
endmodule

// ---- hbrp_bus_if.sv ----
// Shared front-side request bus with open-drain resolution between the two ends.
`timescale 1ns/1ps
interface hbrp_bus_if import hbrp_pkg::*; ();
  logic dev_strobe_o, dev_strobe_oe, host_strobe_o, host_strobe_oe;
  logic [HBRP_ADDR_W-1:0] dev_addr_o, host_addr_o;
  logic dev_addr_oe, host_addr_oe;
  logic [HBRP_TYPE_W-1:0] dev_type_o, host_type_o;
  logic [HBRP_PAR_W-1:0] dev_par_o, host_par_o;
  logic dev_par_oe, dev_par_weak, host_par_oe;
  logic dev_bnr_o, dev_bnr_oe, host_bnr_o, host_bnr_oe;
  logic dev_fault_o, dev_fault_oe;
  logic request_strobe_n, block_next_req_n, bus_fault_pin_n;
  logic [HBRP_ADDR_W-1:0] host_addr_n;
  logic [HBRP_TYPE_W-1:0] req_type_n;
  logic [HBRP_PAR_W-1:0] request_parity_n;
  logic [HBRP_PAR_W-1:0] par_pull;

  // Any enabled low driver pulls a line low; otherwise the termination holds it high.
  assign request_strobe_n = ~((dev_strobe_oe & ~dev_strobe_o) | (host_strobe_oe & ~host_strobe_o));
  assign block_next_req_n = ~((dev_bnr_oe & ~dev_bnr_o) | (host_bnr_oe & ~host_bnr_o));
  assign bus_fault_pin_n = ~(dev_fault_oe & ~dev_fault_o);
  assign host_addr_n = ~(({HBRP_ADDR_W{dev_addr_oe}} & ~dev_addr_o)
                       | ({HBRP_ADDR_W{host_addr_oe}} & ~host_addr_o));
  assign req_type_n = ~(({HBRP_TYPE_W{dev_addr_oe}} & ~dev_type_o)
                      | ({HBRP_TYPE_W{host_addr_oe}} & ~host_type_o));
  // A weak keeper on the hub's parity outputs holds their last value when nothing drives.
  assign par_pull = (dev_par_weak & ~host_par_oe) ? dev_par_o : HBRP_PAR_RST;
  assign request_parity_n = par_pull & ~(({HBRP_PAR_W{dev_par_oe}} & ~dev_par_o)
                                       | ({HBRP_PAR_W{host_par_oe}} & ~host_par_o));

  modport hub (
    output dev_strobe_o, dev_strobe_oe, dev_addr_o, dev_addr_oe, dev_type_o,
    output dev_par_o, dev_par_oe, dev_par_weak, dev_bnr_o, dev_bnr_oe,
    output dev_fault_o, dev_fault_oe,
    input request_strobe_n, host_addr_n, req_type_n, request_parity_n, block_next_req_n
  );
  modport host (
    output host_strobe_o, host_strobe_oe, host_addr_o, host_addr_oe, host_type_o,
    output host_par_o, host_par_oe, host_bnr_o, host_bnr_oe,
    input request_strobe_n, host_addr_n, req_type_n, request_parity_n, block_next_req_n
  );
endinterface

// ---- hbrp_host_end.sv ----
// Processor-side end: issues requests, honours blocking and checks request parity.
`timescale 1ns/1ps
module hbrp_host_end import hbrp_pkg::*; (
  input wire logic i_clk_sys, // System bus clock.
  input wire logic i_resetn, // Synchronous reset, active low.
  input wire logic i_clk_en, // Clock enable; state holds while low.
  hbrp_bus_if.host bus, // Shared request bus.
  input wire logic i_bus_owner, // This end owns the request bus.
  input wire logic i_req_valid, // Request offered.
  output logic o_req_ready, // Request taken this cycle.
  input wire logic [HBRP_ADDR_W-1:0] i_req_addr_a, // Sub-phase A address value.
  input wire logic [HBRP_ADDR_W-1:0] i_req_addr_b, // Sub-phase B address-line value.
  input wire logic [HBRP_TYPE_W-1:0] i_req_type_a, // Sub-phase A request type.
  input wire logic [HBRP_TYPE_W-1:0] i_req_type_b, // Sub-phase B request type.
  input wire logic i_block_req, // Ask the owner to hold further requests.
  output logic o_rx_valid, // Observed request complete, one cycle.
  output logic [HBRP_ADDR_W-1:0] o_rx_addr_a, // Observed sub-phase A address.
  output logic [HBRP_ADDR_W-1:0] o_rx_addr_b, // Observed sub-phase B address lines.
  output logic [HBRP_TYPE_W-1:0] o_rx_type_a, // Observed sub-phase A type.
  output logic [HBRP_TYPE_W-1:0] o_rx_type_b, // Observed sub-phase B type.
  output logic o_parity_err // Parity error on observed request, one cycle.
);
  hbrp_iss_type iss_q, iss_d;
  hbrp_rx_type rx_q, rx_d;
  logic strobe_o_q, strobe_o_d, strobe_oe_q, strobe_oe_d, addr_oe_q, addr_oe_d;
  logic par_oe_q, par_oe_d, valid_q, valid_d, err_q, err_d;
  logic [HBRP_ADDR_W-1:0] addr_o_q, addr_o_d, nxt_addr_q, nxt_addr_d;
  logic [HBRP_ADDR_W-1:0] ra_q, ra_d, rb_q, rb_d;
  logic [HBRP_TYPE_W-1:0] type_o_q, type_o_d, nxt_type_q, nxt_type_d;
  logic [HBRP_TYPE_W-1:0] ta_q, ta_d, tb_q, tb_d;
  logic [HBRP_PAR_W-1:0] par_o_q, par_o_d, pa_q, pa_d;

  // A request is taken only while owning the bus and not blocked.
  assign o_req_ready = (iss_q == ISS_IDLE) & i_bus_owner & bus.block_next_req_n;

  // Issue sequence and observation of the other end's requests.
  always_comb begin
    iss_d = iss_q;
    strobe_o_d = strobe_o_q;
    strobe_oe_d = strobe_oe_q;
    addr_o_d = addr_o_q;
    addr_oe_d = addr_oe_q;
    type_o_d = type_o_q;
    nxt_addr_d = nxt_addr_q;
    nxt_type_d = nxt_type_q;
    par_o_d = par_o_q;
    par_oe_d = par_oe_q;
    rx_d = rx_q;
    ra_d = ra_q;
    rb_d = rb_q;
    ta_d = ta_q;
    tb_d = tb_q;
    pa_d = pa_q;
    valid_d = 1'b0;
    err_d = 1'b0;
    unique case (iss_q)
      ISS_IDLE: begin
        if (i_req_valid && o_req_ready) begin
          iss_d = ISS_SUB_A;
          strobe_o_d = 1'b0;
          strobe_oe_d = 1'b1;
          addr_o_d = ~i_req_addr_a;
          type_o_d = ~i_req_type_a;
          addr_oe_d = 1'b1;
          nxt_addr_d = ~i_req_addr_b;
          nxt_type_d = ~i_req_type_b;
        end
      end
      ISS_SUB_A: begin
        iss_d = ISS_SUB_B;
        strobe_o_d = 1'b1;
        addr_o_d = nxt_addr_q;
        type_o_d = nxt_type_q;
        par_o_d = hbrp_ap_lines(addr_o_q, type_o_q, 1'b0);
        par_oe_d = 1'b1;
      end
      ISS_SUB_B: begin
        iss_d = ISS_PAR_B;
        strobe_oe_d = 1'b0;
        addr_oe_d = 1'b0;
        par_o_d = hbrp_ap_lines(addr_o_q, type_o_q, 1'b1);
      end
      ISS_PAR_B: begin
        iss_d = ISS_IDLE;
        par_oe_d = 1'b0;
      end
    endcase
    unique case (rx_q)
      RX_IDLE: begin
        if (!bus.request_strobe_n && iss_q == ISS_IDLE) begin
          rx_d = RX_SUB_B;
          ra_d = bus.host_addr_n;
          ta_d = bus.req_type_n;
        end
      end
      RX_SUB_B: begin
        rx_d = RX_PAR_B;
        rb_d = bus.host_addr_n;
        tb_d = bus.req_type_n;
        pa_d = bus.request_parity_n;
      end
      RX_PAR_B: begin
        rx_d = RX_IDLE;
        valid_d = 1'b1;
        err_d = (hbrp_ap_lines(ra_q, ta_q, 1'b0) != pa_q)
              | (hbrp_ap_lines(rb_q, tb_q, 1'b1) != bus.request_parity_n);
      end
      default: rx_d = RX_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      iss_q <= ISS_IDLE;
      rx_q <= RX_IDLE;
      strobe_o_q <= HBRP_LINE_IDLE;
      strobe_oe_q <= 1'b0;
      addr_o_q <= HBRP_ADDR_RST;
      addr_oe_q <= 1'b0;
      type_o_q <= HBRP_TYPE_RST;
      nxt_addr_q <= HBRP_ADDR_RST;
      nxt_type_q <= HBRP_TYPE_RST;
      par_o_q <= HBRP_PAR_RST;
      par_oe_q <= 1'b0;
      ra_q <= HBRP_ADDR_RST;
      rb_q <= HBRP_ADDR_RST;
      ta_q <= HBRP_TYPE_RST;
      tb_q <= HBRP_TYPE_RST;
      pa_q <= HBRP_PAR_RST;
      valid_q <= 1'b0;
      err_q <= 1'b0;
    end else if (i_clk_en) begin
      iss_q <= iss_d;
      rx_q <= rx_d;
      strobe_o_q <= strobe_o_d;
      strobe_oe_q <= strobe_oe_d;
      addr_o_q <= addr_o_d;
      addr_oe_q <= addr_oe_d;
      type_o_q <= type_o_d;
      nxt_addr_q <= nxt_addr_d;
      nxt_type_q <= nxt_type_d;
      par_o_q <= par_o_d;
      par_oe_q <= par_oe_d;
      ra_q <= ra_d;
      rb_q <= rb_d;
      ta_q <= ta_d;
      tb_q <= tb_d;
      pa_q <= pa_d;
      valid_q <= valid_d;
      err_q <= err_d;
    end
  end

  // Bus drive and user-side results; line values are inverted to internal values.
  assign bus.host_strobe_o = strobe_o_q;
  assign bus.host_strobe_oe = strobe_oe_q;
  assign bus.host_addr_o = addr_o_q;
  assign bus.host_type_o = type_o_q;
  assign bus.host_addr_oe = addr_oe_q;
  assign bus.host_par_o = par_o_q;
  assign bus.host_par_oe = par_oe_q;
  assign bus.host_bnr_o = 1'b0;
  assign bus.host_bnr_oe = i_block_req;
  assign o_rx_valid = valid_q;
  assign o_parity_err = err_q;
  assign o_rx_addr_a = ~ra_q;
  assign o_rx_addr_b = ~rb_q;
  assign o_rx_type_a = ~ta_q;
  assign o_rx_type_b = ~tb_q;
endmodule

// ---- hbrp_hub_end.sv ----
// Hub-side end of the request bus: request issue, parity check, error message, blocking.
`timescale 1ns/1ps
module hbrp_hub_end import hbrp_pkg::*; (
  input wire logic i_clk_sys, // System bus clock.
  input wire logic i_resetn, // Synchronous reset, active low.
  input wire logic i_clk_en, // Clock enable; state holds while low.
  hbrp_bus_if.hub bus, // Shared request bus.
  input wire logic i_bus_owner, // This end owns the request bus.
  input wire logic i_req_valid, // Request offered.
  output logic o_req_ready, // Request taken this cycle.
  input wire logic [HBRP_ADDR_W-1:0] i_req_addr_a, // Sub-phase A address value.
  input wire logic [HBRP_ADDR_W-1:0] i_req_addr_b, // Sub-phase B address-line value.
  input wire logic [HBRP_TYPE_W-1:0] i_req_type_a, // Sub-phase A request type.
  input wire logic [HBRP_TYPE_W-1:0] i_req_type_b, // Sub-phase B request type.
  input wire logic i_block_req, // Ask the owner to hold further requests.
  input wire logic i_err_msg_en, // Send a message on address parity error.
  output logic o_rx_valid, // Observed request complete, one cycle.
  output logic [HBRP_ADDR_W-1:0] o_rx_addr_a, // Observed sub-phase A address.
  output logic [HBRP_ADDR_W-1:0] o_rx_addr_b, // Observed sub-phase B address lines.
  output logic [HBRP_TYPE_W-1:0] o_rx_type_a, // Observed sub-phase A type.
  output logic [HBRP_TYPE_W-1:0] o_rx_type_b, // Observed sub-phase B type.
  output logic o_parity_err, // Parity error on observed request, one cycle.
  output logic o_err_msg // Error message strobe toward the hub link.
);
  hbrp_iss_type iss_q, iss_d;
  hbrp_rx_type rx_q, rx_d;
  hbrp_bnr_type bnr_q, bnr_d;
  logic strobe_o_q, strobe_o_d, strobe_oe_q, strobe_oe_d, addr_oe_q, addr_oe_d;
  logic par_oe_q, par_oe_d, par_weak_q, par_weak_d;
  logic bnr_o_q, bnr_o_d, bnr_oe_q, bnr_oe_d;
  logic valid_q, valid_d, err_q, err_d, msg_q, msg_d;
  logic [HBRP_ADDR_W-1:0] addr_o_q, addr_o_d, nxt_addr_q, nxt_addr_d;
  logic [HBRP_ADDR_W-1:0] ra_q, ra_d, rb_q, rb_d;
  logic [HBRP_TYPE_W-1:0] type_o_q, type_o_d, nxt_type_q, nxt_type_d;
  logic [HBRP_TYPE_W-1:0] ta_q, ta_d, tb_q, tb_d;
  logic [HBRP_PAR_W-1:0] par_o_q, par_o_d, pa_q, pa_d;
  logic rx_err;

  // A request is taken only while owning the bus and not blocked.
  assign o_req_ready = (iss_q == ISS_IDLE) & i_bus_owner & bus.block_next_req_n;

  // Parity judged on line levels of both sub-phases.
  assign rx_err = (hbrp_ap_lines(ra_q, ta_q, 1'b0) != pa_q)
                | (hbrp_ap_lines(rb_q, tb_q, 1'b1) != bus.request_parity_n);

  // Issue sequence: strobe low, then high, then released; parity trails each sub-phase.
  always_comb begin
    iss_d = iss_q;
    strobe_o_d = strobe_o_q;
    strobe_oe_d = strobe_oe_q;
    addr_o_d = addr_o_q;
    addr_oe_d = addr_oe_q;
    type_o_d = type_o_q;
    nxt_addr_d = nxt_addr_q;
    nxt_type_d = nxt_type_q;
    par_o_d = par_o_q;
    par_oe_d = par_oe_q;
    par_weak_d = par_weak_q;
    unique case (iss_q)
      ISS_IDLE: begin
        if (i_req_valid && o_req_ready) begin
          iss_d = ISS_SUB_A;
          strobe_o_d = 1'b0;
          strobe_oe_d = 1'b1;
          addr_o_d = ~i_req_addr_a;
          type_o_d = ~i_req_type_a;
          addr_oe_d = 1'b1;
          nxt_addr_d = ~i_req_addr_b;
          nxt_type_d = ~i_req_type_b;
        end
      end
      ISS_SUB_A: begin
        iss_d = ISS_SUB_B;
        strobe_o_d = 1'b1;
        addr_o_d = nxt_addr_q;
        type_o_d = nxt_type_q;
        par_o_d = hbrp_ap_lines(addr_o_q, type_o_q, 1'b0);
        par_oe_d = 1'b1;
        par_weak_d = 1'b0;
      end
      ISS_SUB_B: begin
        iss_d = ISS_PAR_B;
        strobe_oe_d = 1'b0;
        addr_oe_d = 1'b0;
        par_o_d = hbrp_ap_lines(addr_o_q, type_o_q, 1'b1);
      end
      ISS_PAR_B: begin
        iss_d = ISS_IDLE;
        par_oe_d = 1'b0;
        par_weak_d = 1'b1;
      end
    endcase
  end

  // Observation of the other end's requests; a strobe is taken only in RX_IDLE while not issuing.
  always_comb begin
    rx_d = rx_q;
    ra_d = ra_q;
    rb_d = rb_q;
    ta_d = ta_q;
    tb_d = tb_q;
    pa_d = pa_q;
    valid_d = 1'b0;
    err_d = 1'b0;
    msg_d = 1'b0;
    unique case (rx_q)
      RX_IDLE: begin
        if (!bus.request_strobe_n && iss_q == ISS_IDLE) begin
          rx_d = RX_SUB_B;
          ra_d = bus.host_addr_n;
          ta_d = bus.req_type_n;
        end
      end
      RX_SUB_B: begin
        rx_d = RX_PAR_B;
        rb_d = bus.host_addr_n;
        tb_d = bus.req_type_n;
        pa_d = bus.request_parity_n;
      end
      RX_PAR_B: begin
        rx_d = RX_IDLE;
        valid_d = 1'b1;
        err_d = rx_err;
        msg_d = rx_err & i_err_msg_en;
      end
      default: rx_d = RX_IDLE;
    endcase
  end

  // Block-next-request: asserted while asked, then driven high a clock, then released.
  always_comb begin
    bnr_d = bnr_q;
    bnr_o_d = bnr_o_q;
    bnr_oe_d = bnr_oe_q;
    unique case (bnr_q)
      BNR_IDLE: begin
        if (i_block_req) begin
          bnr_d = BNR_ASSERT;
          bnr_o_d = 1'b0;
          bnr_oe_d = 1'b1;
        end
      end
      BNR_ASSERT: begin
        if (!i_block_req) begin
          bnr_d = BNR_RELEASE;
          bnr_o_d = 1'b1;
        end
      end
      BNR_RELEASE: begin
        bnr_d = BNR_IDLE;
        bnr_oe_d = 1'b0;
      end
      default: begin
        bnr_d = BNR_IDLE;
        bnr_oe_d = 1'b0;
      end
    endcase
  end

  // Issue and blocking registers.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      iss_q <= ISS_IDLE;
      bnr_q <= BNR_IDLE;
      strobe_o_q <= HBRP_LINE_IDLE;
      strobe_oe_q <= 1'b0;
      addr_o_q <= HBRP_ADDR_RST;
      addr_oe_q <= 1'b0;
      type_o_q <= HBRP_TYPE_RST;
      nxt_addr_q <= HBRP_ADDR_RST;
      nxt_type_q <= HBRP_TYPE_RST;
      par_o_q <= HBRP_PAR_RST;
      par_oe_q <= 1'b0;
      par_weak_q <= 1'b0;
      bnr_o_q <= HBRP_LINE_IDLE;
      bnr_oe_q <= 1'b0;
    end else if (i_clk_en) begin
      iss_q <= iss_d;
      bnr_q <= bnr_d;
      strobe_o_q <= strobe_o_d;
      strobe_oe_q <= strobe_oe_d;
      addr_o_q <= addr_o_d;
      addr_oe_q <= addr_oe_d;
      type_o_q <= type_o_d;
      nxt_addr_q <= nxt_addr_d;
      nxt_type_q <= nxt_type_d;
      par_o_q <= par_o_d;
      par_oe_q <= par_oe_d;
      par_weak_q <= par_weak_d;
      bnr_o_q <= bnr_o_d;
      bnr_oe_q <= bnr_oe_d;
    end
  end

  // Observation registers.
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      rx_q <= RX_IDLE;
      ra_q <= HBRP_ADDR_RST;
      rb_q <= HBRP_ADDR_RST;
      ta_q <= HBRP_TYPE_RST;
      tb_q <= HBRP_TYPE_RST;
      pa_q <= HBRP_PAR_RST;
      valid_q <= 1'b0;
      err_q <= 1'b0;
      msg_q <= 1'b0;
    end else if (i_clk_en) begin
      rx_q <= rx_d;
      ra_q <= ra_d;
      rb_q <= rb_d;
      ta_q <= ta_d;
      tb_q <= tb_d;
      pa_q <= pa_d;
      valid_q <= valid_d;
      err_q <= err_d;
      msg_q <= msg_d;
    end
  end

  // Bus drive; the bus fault pin is left to its termination alone.
  assign bus.dev_strobe_o = strobe_o_q;
  assign bus.dev_strobe_oe = strobe_oe_q;
  assign bus.dev_addr_o = addr_o_q;
  assign bus.dev_type_o = type_o_q;
  assign bus.dev_addr_oe = addr_oe_q;
  assign bus.dev_par_o = par_o_q;
  assign bus.dev_par_oe = par_oe_q;
  assign bus.dev_par_weak = par_weak_q;
  assign bus.dev_bnr_o = bnr_o_q;
  assign bus.dev_bnr_oe = bnr_oe_q;
  assign bus.dev_fault_o = HBRP_LINE_IDLE;
  assign bus.dev_fault_oe = 1'b0;

  // User-side results, inverted back to internal values.
  assign o_rx_valid = valid_q;
  assign o_parity_err = err_q;
  assign o_err_msg = msg_q;
  assign o_rx_addr_a = ~ra_q;
  assign o_rx_addr_b = ~rb_q;
  assign o_rx_type_a = ~ta_q;
  assign o_rx_type_b = ~tb_q;
endmodule

// ---- hbrp_pkg.sv ----
// Shared constants, state types and parity helper for the request-phase bus block.
package hbrp_pkg;
  // Width of the address lines, bit 0 standing for address bit 3.
  localparam int HBRP_ADDR_W = 33;
  // Width of the request-type lines.
  localparam int HBRP_TYPE_W = 5;
  // Index of address bit 24 within the address vector.
  localparam int HBRP_HI_LSB = 21;
  // Width of the request parity lines.
  localparam int HBRP_PAR_W = 2;
  // Clocks from a sub-phase to the parity that covers it.
  localparam int HBRP_PAR_DELAY = 1;
  // Values after reset.
  localparam logic [HBRP_ADDR_W-1:0] HBRP_ADDR_RST = 33'h0_0000_0000;
  localparam logic [HBRP_TYPE_W-1:0] HBRP_TYPE_RST = 5'h00;
  localparam logic [HBRP_PAR_W-1:0] HBRP_PAR_RST = 2'h3;
  localparam logic HBRP_LINE_IDLE = 1'b1;

  // Request issue sequence: two sub-phases, then the trailing parity clock.
  typedef enum logic [1:0] {ISS_IDLE, ISS_SUB_A, ISS_SUB_B, ISS_PAR_B} hbrp_iss_type;
  // Request observation sequence.
  typedef enum logic [1:0] {RX_IDLE, RX_SUB_B, RX_PAR_B} hbrp_rx_type;
  // Block-next-request drive sequence.
  typedef enum logic [1:0] {BNR_IDLE, BNR_ASSERT, BNR_RELEASE} hbrp_bnr_type;

  // Parity line levels {p1, p0} for one sub-phase, computed on line levels.
  // A group is correct when its low lines plus its parity line are even in number.
  function automatic logic [HBRP_PAR_W-1:0] hbrp_ap_lines(
    input logic [HBRP_ADDR_W-1:0] a,
    input logic [HBRP_TYPE_W-1:0] t,
    input logic sub_b
  );
    logic hi;
    logic lo;
    hi = ~(^(~a[HBRP_ADDR_W-1:HBRP_HI_LSB]));
    lo = ~(^(~{a[HBRP_HI_LSB-1:0], t}));
    return sub_b ? {hi, lo} : {lo, hi};
  endfunction
endpackage

// ---- host_bus_request_parity_tb_top.sv ----
// Bench joining both request-bus ends, plus a hub fed by a faulty driver.
`timescale 1ns/1ps
module host_bus_request_parity_tb_top import hbrp_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic err_en = 1'b0;
  logic [1:0] own = 2'h0, val = 2'h0, blk = 2'h0, rdy, rxv, perr;
  logic [HBRP_ADDR_W-1:0] ra = HBRP_ADDR_RST, rb = HBRP_ADDR_RST, v, w;
  logic [HBRP_TYPE_W-1:0] ta = HBRP_TYPE_RST, tb = HBRP_TYPE_RST;
  logic [1:0][HBRP_ADDR_W-1:0] rxa, rxb;
  logic [1:0][HBRP_TYPE_W-1:0] rxta, rxtb;
  logic rxv2, perr2, msg2, msg;
  logic [31:0] seed = 32'h0000_0023;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;

  hbrp_bus_if bus ();
  hbrp_bus_if bus2 ();
  // Index 0 is the hub end, index 1 the host end.
  hbrp_hub_end hbrp_hub_end_i (.i_clk_sys(clk), .i_resetn(rst_n), .i_clk_en(clk_en), .bus(bus),
    .i_bus_owner(own[0]), .i_req_valid(val[0]), .o_req_ready(rdy[0]), .i_req_addr_a(ra),
    .i_req_addr_b(rb), .i_req_type_a(ta), .i_req_type_b(tb), .i_block_req(blk[0]),
    .i_err_msg_en(err_en), .o_rx_valid(rxv[0]), .o_rx_addr_a(rxa[0]), .o_rx_addr_b(rxb[0]),
    .o_rx_type_a(rxta[0]), .o_rx_type_b(rxtb[0]), .o_parity_err(perr[0]), .o_err_msg(msg));
  hbrp_host_end hbrp_host_end_i (.i_clk_sys(clk), .i_resetn(rst_n), .i_clk_en(clk_en), .bus(bus),
    .i_bus_owner(own[1]), .i_req_valid(val[1]), .o_req_ready(rdy[1]), .i_req_addr_a(ra),
    .i_req_addr_b(rb), .i_req_type_a(ta), .i_req_type_b(tb), .i_block_req(blk[1]),
    .o_rx_valid(rxv[1]), .o_rx_addr_a(rxa[1]), .o_rx_addr_b(rxb[1]),
    .o_rx_type_a(rxta[1]), .o_rx_type_b(rxtb[1]), .o_parity_err(perr[1]));
  hbrp_hub_end hbrp_hub_end_i2 (.i_clk_sys(clk), .i_resetn(rst_n), .i_clk_en(clk_en), .bus(bus2),
    .i_bus_owner(1'b0), .i_req_valid(1'b0), .o_req_ready(), .i_req_addr_a(ra),
    .i_req_addr_b(rb), .i_req_type_a(ta), .i_req_type_b(tb), .i_block_req(blk[0]),
    .i_err_msg_en(err_en), .o_rx_valid(rxv2), .o_rx_addr_a(), .o_rx_addr_b(),
    .o_rx_type_a(), .o_rx_type_b(), .o_parity_err(perr2), .o_err_msg(msg2));
  hbrp_bus_asserts hbrp_bus_asserts_i (.i_clk_sys(clk), .i_resetn(rst_n),
    .request_strobe_n(bus.request_strobe_n), .block_next_req_n(bus.block_next_req_n),
    .bus_fault_pin_n(bus.bus_fault_pin_n), .host_addr_n(bus.host_addr_n),
    .req_type_n(bus.req_type_n), .request_parity_n(bus.request_parity_n),
    .dev_strobe_o(bus.dev_strobe_o), .dev_strobe_oe(bus.dev_strobe_oe),
    .dev_addr_oe(bus.dev_addr_oe), .host_addr_oe(bus.host_addr_oe), .dev_par_oe(bus.dev_par_oe),
    .host_par_oe(bus.host_par_oe), .dev_bnr_o(bus.dev_bnr_o), .dev_bnr_oe(bus.dev_bnr_oe),
    .dev_fault_oe(bus.dev_fault_oe));

  // Clock at 200 MHz and a cycle ceiling that cuts a hang short.
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [HBRP_ADDR_W-1:0] seen, input logic [HBRP_ADDR_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rnd(output logic [HBRP_ADDR_W-1:0] r);
    seed = nxt(nxt(seed));
    r = {seed[5], seed};
  endtask
  // Expected parity line levels {p1, p0}; even lows per group including its parity line.
  function automatic logic [1:0] par(input logic [32:0] l, input logic [4:0] t, input logic sb);
    logic hi;
    logic lo;
    hi = ~^(~l[32:21]);
    lo = ~^(~{l[20:0], t});
    return sb ? {hi, lo} : {lo, hi};
  endfunction

  // One request from end s, checked on the wire and at the other end.
  task automatic send(input int s, input logic [32:0] a, input logic [32:0] b,
                      input logic [4:0] x, input logic [4:0] y);
    int n;
    n = 0;
    ra = a;
    rb = b;
    ta = x;
    tb = y;
    own = s ? 2'h2 : 2'h1;
    val = own;
    while (rdy[s] !== 1'b1 && n < 30) begin
      step(1);
      n++;
    end
    check(33'(n < 30), 33'h1);
    step(1);
    val = 2'h0;
    check(33'(bus.request_strobe_n), 33'h0);
    check(bus.host_addr_n, ~a);
    step(1);
    check(bus.host_addr_n, ~b);
    n = 0;
    while (rxv[1-s] !== 1'b1 && n < 8) begin
      step(1);
      n++;
    end
    check(rxa[1-s], a);
    check(rxb[1-s], b);
    check(33'({rxta[1-s], rxtb[1-s], perr[1-s], msg}), 33'({x, y, 2'h0}));
  endtask

  // A hand-driven frame on the second bus with parity bits flipped by f.
  task automatic frame2(input logic [32:0] a, input logic [32:0] b, input logic [1:0] f,
                        input logic en);
    int n;
    n = 0;
    err_en = en;
    bus2.host_strobe_o = 1'b0;
    bus2.host_strobe_oe = 1'b1;
    bus2.host_addr_oe = 1'b1;
    bus2.host_addr_o = ~a;
    bus2.host_type_o = ~a[4:0];
    step(1);
    bus2.host_strobe_o = 1'b1;
    bus2.host_addr_o = ~b;
    bus2.host_type_o = ~b[4:0];
    bus2.host_par_oe = 1'b1;
    bus2.host_par_o = par(~a, ~a[4:0], 1'b0) ^ {1'b0, f[0]};
    step(1);
    bus2.host_strobe_oe = 1'b0;
    bus2.host_addr_oe = 1'b0;
    bus2.host_par_o = par(~b, ~b[4:0], 1'b1) ^ {f[1], 1'b0};
    step(1);
    bus2.host_par_oe = 1'b0;
    while (rxv2 !== 1'b1 && n < 8) begin
      step(1);
      n++;
    end
    check(33'({rxv2, perr2, msg2}), 33'({1'b1, f != 2'h0, en && f != 2'h0}));
  endtask

  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence: corners, random traffic, reset, blocking, parity faults.
  initial begin
    bus2.host_strobe_o = 1'b1;
    bus2.host_strobe_oe = 1'b0;
    bus2.host_addr_o = HBRP_ADDR_RST;
    bus2.host_addr_oe = 1'b0;
    bus2.host_type_o = HBRP_TYPE_RST;
    bus2.host_par_o = HBRP_PAR_RST;
    bus2.host_par_oe = 1'b0;
    bus2.host_bnr_o = 1'b1;
    bus2.host_bnr_oe = 1'b0;
    step(4);
    rst_n = 1'b1;
    send(0, 33'h0_0000_0000, 33'h1_ffff_ffff, 5'h00, 5'h1f);
    send(1, 33'h1_ffff_ffff, 33'h0_0000_0000, 5'h1f, 5'h00);
    for (int i = 0; i < 40; i++) begin
      rnd(v);
      rnd(w);
      send(seed[3], v, w, v[4:0], w[9:5]);
    end
    $display("test traffic done");
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    // Observed addresses read all ones after reset.
    check(rxa[0] & rxa[1], ~HBRP_ADDR_RST);
    // Frozen ends take no request.
    clk_en = 1'b0;
    own = 2'h1;
    val = own;
    step(3);
    check(33'(bus.request_strobe_n), 33'h1);
    clk_en = 1'b1;
    val = 2'h0;
    for (int s = 0; s < 2; s++) begin
      blk[1-s] = 1'b1;
      step(2);
      check(33'(bus.block_next_req_n), 33'h0);
      own = s ? 2'h2 : 2'h1;
      val = own;
      repeat (5) begin
        check(33'(rdy[s]), 33'h0);
        step(1);
      end
      val = 2'h0;
      blk = 2'h0;
      rnd(v);
      send(s, v, ~v, v[4:0], v[9:5]);
    end
    $display("test blocking done");
    for (int k = 0; k < 8; k++) begin
      rnd(v);
      frame2(v, ~v, k[1:0], k[2]);
    end
    $display("test parity fault done");
    results();
  end
endmodule
